/* hdl/rmc_pkg.sv */
// Purpose: Shared constants and types for the radio module mode and packet control block.
// Assumes: System clock of 125 MHz; all byte streams are 8 bits wide.
// Notes:   Timing counts derive from times in their own units.
package rmc_pkg;
	// System clock rate
	localparam int unsigned CLK_HZ          = 125_000_000;
	// Delay from an idle mode-pin change to the new mode
	localparam int unsigned MODE_SETTLE_MS  = 1;
	localparam int unsigned MODE_SETTLE_CYC = MODE_SETTLE_MS * (CLK_HZ / 1000);
	// Lead between a received packet and serial output
	localparam int unsigned RX_LEAD_MS      = 5;
	localparam int unsigned RX_LEAD_CYC     = RX_LEAD_MS * (CLK_HZ / 1000);
	// Power-up self-test time, busy indicator low meanwhile
	localparam int unsigned SELFTEST_US     = 100;
	localparam int unsigned SELFTEST_CYC    = SELFTEST_US * (CLK_HZ / 1_000_000);
	// Radio packet payload length in bytes
	localparam int unsigned PKT_LEN         = 58;
	// Input allowance after the indicator returns high
	localparam int unsigned IN_BUF_BYTES    = 512;
	// Radio-to-serial buffer depth
	localparam int unsigned OUT_FIFO_DEPTH  = 32;
	// Idle gap, in serial byte times, that ends an input burst
	localparam logic [1:0]  IDLE_BYTE_TIMES = 2'h3;
	// Byte width
	localparam int unsigned BYTE_W          = 8;

	// Working modes, encoded as {high pin, low pin}
	typedef enum logic [1:0] {
		RMC_MODE_GENERAL = 2'h0,
		RMC_MODE_WAKE    = 2'h1,
		RMC_MODE_SAVE    = 2'h2,
		RMC_MODE_SLEEP   = 2'h3
	} rmc_mode_type;

	// Mode control states, Gray along the usual path
	typedef enum logic [1:0] {
		MS_SELFTEST = 2'h0,
		MS_RUN      = 2'h1,
		MS_SETTLE   = 2'h3
	} rmc_ms_type;

	// Radio transmit states
	typedef enum logic [1:0] {
		TX_IDLE  = 2'h0,
		TX_START = 2'h1,
		TX_SEND  = 2'h3
	} rmc_tx_type;

	// Serial output states
	typedef enum logic [1:0] {
		OUT_IDLE  = 2'h0,
		OUT_LEAD  = 2'h1,
		OUT_DRAIN = 2'h3
	} rmc_out_type;
endpackage

/* hdl/rmc_framer.sv */
// Purpose: Mode switching and packet framing between a serial link and a radio modem.
// Assumes: Serial bytes come from a UART on the same clock; mode pins are asynchronous.
// Notes:   The radio modem itself, power saving and the parameter commands live elsewhere.
`timescale 1ns/1ps
`default_nettype none

// Plain synchronous FIFO with valid/ready on both sides
module rmc_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_resetn,
	// Fill side
	input  wire logic                       i_in_valid,
	input  wire logic [WIDTH-1:0]           i_in_data,
	output logic                            o_in_ready,
	// Drain side
	output logic                            o_out_valid,
	output logic [WIDTH-1:0]                o_out_data,
	input  wire logic                       i_out_ready,
	// Fill level
	output logic [$clog2(DEPTH+1)-1:0]      o_count
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];       // Storage array
	logic [AW-1:0]    wr_ptr_ff;         // Next write slot
	logic [AW-1:0]    rd_ptr_ff;         // Next read slot
	logic [CW-1:0]    count_ff;          // Words held
	logic             push;              // Accepted write
	logic             pop;               // Accepted read

	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;
	// Full only when every slot holds data
	assign o_in_ready  = (count_ff != CW'(DEPTH));
	assign o_out_valid = (count_ff != '0);
	assign o_out_data  = mem[rd_ptr_ff];
	assign o_count     = count_ff;

	// Storage writes, no reset needed on data
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_ptr_ff] <= i_in_data;
		end
	end

	// Pointers wrap at the depth, not at a power of two
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + CW'(push) - CW'(pop);
		end
	end
endmodule

// Top: mode control, input packetiser, radio-to-serial output
module rmc_framer
	import rmc_pkg::*;
#(
	parameter int unsigned SETTLE_CYC = rmc_pkg::MODE_SETTLE_CYC,
	parameter int unsigned LEAD_CYC   = rmc_pkg::RX_LEAD_CYC,
	parameter int unsigned SELF_CYC   = rmc_pkg::SELFTEST_CYC,
	parameter int unsigned IN_DEPTH   = rmc_pkg::IN_BUF_BYTES,
	parameter int unsigned OUT_DEPTH  = rmc_pkg::OUT_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_resetn,
	// Mode-select pins, asynchronous
	input  wire logic                        i_mode_select_low_pin,
	input  wire logic                        i_mode_select_high_pin,
	// Serial configuration
	input  wire logic [15:0]                 i_baud_div,
	input  wire logic [3:0]                  i_frame_bits,
	input  wire logic [7:0]                  i_wake_time,
	// Serial input bytes from the UART receiver
	input  wire logic                        i_ser_valid,
	input  wire logic [rmc_pkg::BYTE_W-1:0]  i_ser_data,
	output logic                             o_ser_ready,
	// Serial output bytes to the UART transmitter
	output logic                             o_txd_valid,
	output logic [rmc_pkg::BYTE_W-1:0]       o_txd_data,
	input  wire logic                        i_txd_ready,
	// Radio transmit stream
	output logic                             o_rf_tx_start,
	output logic                             o_rf_tx_wake,
	output logic [7:0]                       o_rf_wake_len,
	output logic                             o_rf_tx_valid,
	output logic [rmc_pkg::BYTE_W-1:0]       o_rf_tx_data,
	output logic                             o_rf_tx_last,
	input  wire logic                        i_rf_tx_ready,
	// Radio receive stream
	output logic                             o_rf_rx_enable,
	input  wire logic                        i_rf_rx_valid,
	input  wire logic [rmc_pkg::BYTE_W-1:0]  i_rf_rx_data,
	input  wire logic                        i_rf_rx_last,
	output logic                             o_rf_rx_ready,
	// Status
	output logic                             o_idle_ind,
	output rmc_pkg::rmc_mode_type            o_mode
);
	localparam int unsigned ICW = $clog2(IN_DEPTH+1);
	localparam int unsigned OCW = $clog2(OUT_DEPTH+1);

	logic [1:0]         pin_meta_ff;       // First synchroniser stage
	logic [1:0]         pin_sync_ff;       // Second stage, safe to read
	rmc_mode_type       pin_mode;          // Decoded pin request
	rmc_mode_type       mode_ff;           // Active working mode
	rmc_ms_type         ms_state_ff;       // Mode control state
	logic [31:0]        ms_cnt_ff;         // Self-test and settle timer
	rmc_tx_type         tx_state_ff;       // Radio transmit state
	logic [5:0]         pkt_left_ff;       // Bytes left in current packet
	rmc_out_type        out_state_ff;      // Serial output state
	logic [31:0]        lead_cnt_ff;       // Receive lead timer
	logic               rx_open_ff;        // Packet bytes still arriving
	logic [15:0]        baud_cnt_ff;       // Bit-time divider
	logic               bit_tick;          // One pulse per bit time
	logic [5:0]         idle_bits_ff;      // Idle bit times since last byte
	logic               idle_to_ff;        // Input burst ended
	logic [5:0]         idle_limit;        // Three byte times in bits
	logic [ICW-1:0]     in_count;          // Input bytes pending
	logic [OCW-1:0]     out_count;         // Output bytes pending
	logic               in_push;           // Input byte accepted
	logic               in_pop;            // Byte handed to radio
	logic               rx_push;           // Received byte accepted
	logic               out_valid;         // Output buffer not empty
	logic               busy;              // Any low condition
	logic               idle_ff;           // Registered indicator
	logic               in_avail;          // Input buffer has a byte

	// Pins pass two flops before any decode
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_meta_ff <= 2'h0;
			pin_sync_ff <= 2'h0;
		end else begin
			pin_meta_ff <= {i_mode_select_high_pin, i_mode_select_low_pin};
			pin_sync_ff <= pin_meta_ff;
		end
	end

	assign pin_mode = rmc_mode_type'(pin_sync_ff);

	// Input buffer sized for the full allowance
	// 512-byte input allowance
	rmc_fifo #(.WIDTH(BYTE_W), .DEPTH(IN_DEPTH)) u_in_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_resetn    (i_resetn),
		.i_in_valid  (i_ser_valid),
		.i_in_data   (i_ser_data),
		.o_in_ready  (o_ser_ready),
		.o_out_valid (in_avail),
		.o_out_data  (o_rf_tx_data),
		.i_out_ready (in_pop),
		.o_count     (in_count)
	);
	// Output buffer; back-pressures the modem while full
	rmc_fifo #(.WIDTH(BYTE_W), .DEPTH(OUT_DEPTH)) u_out_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_resetn    (i_resetn),
		.i_in_valid  (i_rf_rx_valid),
		.i_in_data   (i_rf_rx_data),
		.o_in_ready  (o_rf_rx_ready),
		.o_out_valid (out_valid),
		.o_out_data  (o_txd_data),
		.i_out_ready (i_txd_ready && (out_state_ff == OUT_DRAIN)),
		.o_count     (out_count)
	);

	assign in_push       = i_ser_valid && o_ser_ready;
	assign rx_push       = i_rf_rx_valid && o_rf_rx_ready;
	assign o_rf_tx_valid = in_avail && (tx_state_ff == TX_SEND);
	assign in_pop        = o_rf_tx_valid && i_rf_tx_ready;
	assign o_rf_tx_last  = (pkt_left_ff == 6'h1);
	assign o_txd_valid   = out_valid && (out_state_ff == OUT_DRAIN);
	assign o_mode        = mode_ff;
	assign o_idle_ind    = idle_ff;
	assign o_rf_rx_enable = (ms_state_ff != MS_SELFTEST) && (mode_ff != RMC_MODE_SLEEP);

	// Bit-time divider, restarted by every input byte
	// timeout from baud setting
	assign bit_tick   = (baud_cnt_ff == i_baud_div);
	assign idle_limit = 6'(i_frame_bits) * 6'(IDLE_BYTE_TIMES);
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			baud_cnt_ff <= 16'h0;
		end else if (in_push || bit_tick) begin
			baud_cnt_ff <= 16'h0;
		end else begin
			baud_cnt_ff <= baud_cnt_ff + 16'h1;
		end
	end

	// Idle gap counter; a new byte wins over the timeout
	// three byte times idle
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			idle_bits_ff <= 6'h0;
			idle_to_ff   <= 1'b0;
		end else if (in_push) begin
			idle_bits_ff <= 6'h0;
			idle_to_ff   <= 1'b0;
		end else if (bit_tick && !idle_to_ff) begin
			idle_bits_ff <= idle_bits_ff + 6'h1;
			idle_to_ff   <= (idle_bits_ff + 6'h1 >= idle_limit);
		end
	end

	// Packetiser: full packets at once, remainder after idle gap
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			tx_state_ff   <= TX_IDLE;
			pkt_left_ff   <= 6'h0;
			o_rf_tx_start <= 1'b0;
			o_rf_tx_wake  <= 1'b0;
			o_rf_wake_len <= 8'h0;
		end else begin
			o_rf_tx_start <= 1'b0;
			case (tx_state_ff)
				TX_IDLE: begin
					if (in_count >= ICW'(PKT_LEN)) begin
						pkt_left_ff <= 6'(PKT_LEN);
						tx_state_ff <= TX_START;
					end else if (in_count != '0 && idle_to_ff) begin
						pkt_left_ff <= 6'(in_count);
						tx_state_ff <= TX_START;
					end
				end
				TX_START: begin
					o_rf_tx_start <= 1'b1;
					o_rf_tx_wake  <= (mode_ff == RMC_MODE_WAKE);
					o_rf_wake_len <= i_wake_time;
					tx_state_ff   <= TX_SEND;
				end
				TX_SEND: begin
					// Input keeps filling while the packet streams
					if (in_pop) begin
						pkt_left_ff <= pkt_left_ff - 6'h1;
						if (pkt_left_ff == 6'h1) begin
							tx_state_ff <= TX_IDLE;
						end
					end
				end
				default: begin
					tx_state_ff <= TX_IDLE;
				end
			endcase
		end
	end

	// Received packet: hold off serial output for the lead time
	// lead before serial output
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			out_state_ff <= OUT_IDLE;
			lead_cnt_ff  <= 32'h0;
			rx_open_ff   <= 1'b0;
		end else begin
			// Packet open from first byte until its last byte
			if (rx_push) begin
				rx_open_ff <= !i_rf_rx_last;
			end
			case (out_state_ff)
				OUT_IDLE: begin
					lead_cnt_ff <= 32'h0;
					if (rx_push) begin
						out_state_ff <= OUT_LEAD;
					end
				end
				OUT_LEAD: begin
					lead_cnt_ff <= lead_cnt_ff + 32'h1;
					if (lead_cnt_ff == 32'(LEAD_CYC - 1)) begin
						out_state_ff <= OUT_DRAIN;
					end
				end
				OUT_DRAIN: begin
					if (out_count == '0 && !rx_open_ff && !rx_push) begin
						out_state_ff <= OUT_IDLE;
					end
				end
				default: begin
					out_state_ff <= OUT_IDLE;
				end
			endcase
		end
	end

	// Busy when any low condition holds
	// input byte drives low
	assign busy = (ms_state_ff == MS_SELFTEST) || in_push || (in_count != '0)
		|| (tx_state_ff != TX_IDLE) || rx_push || (out_state_ff != OUT_IDLE);

	// Indicator register, low during reset and self-test
	// low through self-test
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			idle_ff <= 1'b0;
		end else begin
			idle_ff <= !busy;
		end
	end

	// Mode control: self-test, run, settle before adopting
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ms_state_ff <= MS_SELFTEST;
			ms_cnt_ff   <= 32'h0;
			mode_ff     <= RMC_MODE_GENERAL;
		end else begin
			case (ms_state_ff)
				MS_SELFTEST: begin
					// Pins are caught at the end, not under reset
					ms_cnt_ff <= ms_cnt_ff + 32'h1;
					if (ms_cnt_ff == 32'(SELF_CYC - 1)) begin
						mode_ff     <= pin_mode;
						ms_cnt_ff   <= 32'h0;
						ms_state_ff <= MS_RUN;
					end
				end
				MS_RUN: begin
					if (pin_mode != mode_ff && !busy) begin
						ms_cnt_ff   <= 32'h0;
						ms_state_ff <= MS_SETTLE;
					end
				end
				MS_SETTLE: begin
					if (busy || pin_mode == mode_ff) begin
						ms_state_ff <= MS_RUN;
					end else if (ms_cnt_ff == 32'(SETTLE_CYC - 1)) begin
						mode_ff     <= pin_mode;
						ms_state_ff <= MS_RUN;
					end else begin
						ms_cnt_ff <= ms_cnt_ff + 32'h1;
					end
				end
				default: begin
					ms_state_ff <= MS_SELFTEST;
				end
			endcase
		end
	end

	// Checks on the logic above
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	a_mode_pin_decode: assert property (
		$past(ms_state_ff) == MS_SETTLE && ms_state_ff == MS_RUN && $changed(mode_ff)
		|-> mode_ff == $past(pin_mode)) else $error("adopted mode differs from pins");
	a_mode_sleep_decode: assert property (
		$changed(mode_ff) && mode_ff == RMC_MODE_SLEEP |-> $past(pin_sync_ff) == 2'h3)
		else $error("sleep decode wrong");
	a_switch_idle_only: assert property (
		$changed(mode_ff) && $past(ms_state_ff) != MS_SELFTEST |-> $past(!busy, 2))
		else $error("mode switched while busy");
	a_settle_full_time: assert property (
		$changed(mode_ff) && $past(ms_state_ff) == MS_SETTLE
		|-> $past(ms_cnt_ff) == 32'(SETTLE_CYC - 1)) else $error("settle time wrong");
	a_full_pkt_start: assert property (
		tx_state_ff == TX_IDLE && in_count >= ICW'(PKT_LEN)
		|=> tx_state_ff == TX_START && pkt_left_ff == 6'(PKT_LEN)) else $error("58-byte start missed");
	a_timeout_flush: assert property (
		tx_state_ff == TX_IDLE && in_count != '0 && in_count < ICW'(PKT_LEN) && idle_to_ff
		|=> tx_state_ff == TX_START ##1 o_rf_tx_start) else $error("idle flush missed");
	a_input_drops_ind: assert property (
		in_push |=> !o_idle_ind) else $error("indicator high after input byte");
	a_ind_means_empty: assert property (
		o_idle_ind |-> $past(in_count) == '0 && $past(tx_state_ff) == TX_IDLE)
		else $error("indicator high with input pending");
	a_wake_prefix: assert property (
		o_rf_tx_start |-> o_rf_tx_wake == ($past(mode_ff) == RMC_MODE_WAKE)
		&& o_rf_wake_len == $past(i_wake_time)) else $error("wake prefix wrong");
	a_lead_before_out: assert property (
		out_state_ff == OUT_LEAD && $past(out_state_ff) == OUT_IDLE
		|-> !o_txd_valid throughout (out_state_ff == OUT_LEAD)[*8]) else $error("output before lead");
	a_lead_count: assert property (
		out_state_ff == OUT_DRAIN && $past(out_state_ff) == OUT_LEAD
		|-> $past(lead_cnt_ff) == 32'(LEAD_CYC - 1)) else $error("lead time wrong");
	a_drain_holds_ind: assert property (
		out_state_ff == OUT_DRAIN |=> !o_idle_ind) else $error("indicator high while draining");

	c_full_packet: cover property (tx_state_ff == TX_IDLE ##1 o_rf_tx_start && pkt_left_ff == 6'(PKT_LEN));
	c_short_flush: cover property (idle_to_ff && tx_state_ff == TX_START);
	c_mode_switch: cover property (ms_state_ff == MS_SETTLE ##1 $changed(mode_ff));
	c_rx_drain: cover property (out_state_ff == OUT_DRAIN && o_txd_valid && i_txd_ready);
endmodule

`default_nettype wire

/* dv/rmc_host_model.sv */
// Purpose: Host controller model: mode pins and serial output sink.
// Assumes: Pins change on a rising edge, after the indicator has held high for the hold count given (none when it is 0).
// Notes:   Slow mode stalls the serial output every other cycle.
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
	// Clock
	input  wire logic       i_clk_sys,
	// Serial output from the block
	input  wire logic       i_txd_valid,
	input  wire logic [7:0] i_txd_data,
	output logic            o_txd_ready,
	// Status in, mode pins out
	input  wire logic       i_idle_ind,
	output logic            o_mode_select_low_pin,
	output logic            o_mode_select_high_pin
);
	logic       slow      = 1'b0;  // Stall the sink when set
	logic       ph_ff     = 1'b0;  // Stall phase
	int         cyc       = 0;     // Free-running cycle count
	int         first_cyc = -1;    // Cycle of first byte taken
	int         wait_cyc  = 0;     // Cycles the last mode change waited
	logic [7:0] got[$];            // Bytes taken, in order
	initial begin
		o_mode_select_low_pin  = 1'b0;
		o_mode_select_high_pin = 1'b0;
	end
	assign o_txd_ready = !slow || ph_ff;
	// Sink, records order and first arrival
	always @(posedge i_clk_sys) begin
		cyc   <= cyc + 1;
		ph_ff <= !ph_ff;
		if (i_txd_valid && o_txd_ready) begin
			got.push_back(i_txd_data);
			if (first_cyc < 0)
				first_cyc = cyc;
		end
	end
	task automatic set_mode(input logic [1:0] m, input int hold);
		int n;
		int k;
		n = 0;
		k = 0;
		while (n < hold && k < 2000) begin
			@(posedge i_clk_sys);
			k++;
			n = (i_idle_ind === 1'b1) ? n + 1 : 0;
		end
		wait_cyc = k;
		{o_mode_select_high_pin, o_mode_select_low_pin} <= m;
	endtask
endmodule
`default_nettype wire

/* dv/test_rmc_framer.sv */
// Purpose: Self-checking bench for the mode and packet control block.
// Assumes: Short settle, lead and self-test counts; one byte time is 4 clocks.
// Notes:   The bench plays the radio modem and the serial input source.
`timescale 1ns/1ps
`default_nettype none
module test_rmc_framer;
	import rmc_pkg::*;
	localparam int SETTLE = 20;
	localparam int LEAD   = 30;
	localparam int SELF   = 10;
	localparam int BYTE_CLK = 4;  // Two bits of two clocks each
	logic         i_clk_sys     = 1'b0;
	logic         i_resetn      = 1'b0;
	logic         i_ser_valid   = 1'b0;
	logic [7:0]   i_ser_data    = 8'h00;
	logic         i_rf_tx_ready = 1'b0;
	logic         i_rf_rx_valid = 1'b0;
	logic [7:0]   i_rf_rx_data  = 8'h00;
	logic         i_rf_rx_last  = 1'b0;
	logic         hold_tx       = 1'b0;  // Modem refuses all bytes
	logic [7:0]   wake_time     = 8'h2a; // Wake-time setting
	logic         pin_lo, pin_hi, i_txd_ready, o_ser_ready, o_txd_valid, o_rf_rx_ready;
	logic         o_rf_tx_start, o_rf_tx_wake, o_rf_tx_valid, o_rf_tx_last, o_rf_rx_enable, o_idle_ind;
	logic [7:0]   o_txd_data, o_rf_wake_len, o_rf_tx_data;
	rmc_mode_type o_mode;
	logic [8:0]   txq[$];  // {last, data} as the modem took them
	logic [8:0]   stq[$];  // {wake, length} at each packet start
	int           miscompares = 0;
	int           tests_run   = 0;
	always #4 i_clk_sys = ~i_clk_sys;
	rmc_framer #(.SETTLE_CYC(SETTLE), .LEAD_CYC(LEAD), .SELF_CYC(SELF), .IN_DEPTH(512), .OUT_DEPTH(32)) u_rmc_framer (
		.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_mode_select_low_pin(pin_lo),
		.i_mode_select_high_pin(pin_hi), .i_baud_div(16'h0001), .i_frame_bits(4'h2), .i_wake_time(wake_time),
		.i_ser_valid(i_ser_valid), .i_ser_data(i_ser_data), .o_ser_ready(o_ser_ready),
		.o_txd_valid(o_txd_valid), .o_txd_data(o_txd_data), .i_txd_ready(i_txd_ready),
		.o_rf_tx_start(o_rf_tx_start), .o_rf_tx_wake(o_rf_tx_wake), .o_rf_wake_len(o_rf_wake_len),
		.o_rf_tx_valid(o_rf_tx_valid), .o_rf_tx_data(o_rf_tx_data), .o_rf_tx_last(o_rf_tx_last),
		.i_rf_tx_ready(i_rf_tx_ready), .o_rf_rx_enable(o_rf_rx_enable), .i_rf_rx_valid(i_rf_rx_valid),
		.i_rf_rx_data(i_rf_rx_data), .i_rf_rx_last(i_rf_rx_last), .o_rf_rx_ready(o_rf_rx_ready),
		.o_idle_ind(o_idle_ind), .o_mode(o_mode));
	rmc_host_model u_rmc_host_model (
		.i_clk_sys(i_clk_sys), .i_txd_valid(o_txd_valid), .i_txd_data(o_txd_data), .o_txd_ready(i_txd_ready),
		.i_idle_ind(o_idle_ind), .o_mode_select_low_pin(pin_lo), .o_mode_select_high_pin(pin_hi));
	// Modem: stalls every other cycle, records what it takes
	always @(posedge i_clk_sys) begin
		i_rf_tx_ready <= !hold_tx && !i_rf_tx_ready;
		if (o_rf_tx_valid && i_rf_tx_ready)
			txq.push_back({o_rf_tx_last, o_rf_tx_data});
		if (o_rf_tx_start)
			stq.push_back({o_rf_tx_wake, o_rf_wake_len});
	end
	task automatic end_sim();
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// A used-up bound ends the run
	task automatic bound(input int k);
		if (k >= 2000) begin
			miscompares++;
			end_sim();
		end
	endtask
	task automatic wait_idle(output int n);
		n = 0;
		while (o_idle_ind !== 1'b1 && n < 2000) begin
			@(negedge i_clk_sys);
			n++;
		end
		bound(n);
	endtask
	task automatic wait_mode(input logic [1:0] m, output int n);
		n = 0;
		while (o_mode !== m && n < 2000) begin
			@(negedge i_clk_sys);
			n++;
		end
		bound(n);
	endtask
	// Serial input burst, held until accepted
	task automatic send(input int n, input logic [7:0] base);
		int k;
		@(posedge i_clk_sys);
		for (int i = 0; i < n; i++) begin
			i_ser_valid <= 1'b1;
			i_ser_data  <= base + i[7:0];
			k = 0;
			do begin
				@(negedge i_clk_sys);
				k++;
			end while (o_ser_ready !== 1'b1 && k < 2000);
			bound(k);
			@(posedge i_clk_sys);
		end
		i_ser_valid <= 1'b0;
		i_ser_data  <= ~i_ser_data;
	endtask
	// Packet contents: order and last flags
	task automatic chk_tx(input int n, input logic [7:0] base);
		chk("tx_count", txq.size(), n);
		for (int i = 0; i < n && i < txq.size(); i++)
			chk("tx_byte", txq[i], {(i % PKT_LEN == PKT_LEN - 1) || (i == n - 1), base + i[7:0]});
	endtask
	task automatic t_reset();
		int n;
		repeat (4) @(posedge i_clk_sys);
		chk("idle_in_reset", o_idle_ind, 1'b0);
		i_resetn <= 1'b1;
		wait_idle(n);
		chk("selftest_long", n >= SELF, 1'b1);
		chk("mode_reset", o_mode, RMC_MODE_GENERAL);
	endtask
	task automatic t_short();
		int n;
		txq.delete();
		stq.delete();
		send(5, 8'h10);
		@(negedge i_clk_sys);
		chk("idle_low_input", o_idle_ind, 1'b0);
		// Start pulse only after three byte times of silence
		n = 1;
		while (o_rf_tx_start !== 1'b1 && n < 2000) begin
			@(negedge i_clk_sys);
			n++;
		end
		bound(n);
		chk("idle_gap", n > 3 * BYTE_CLK && n <= 3 * BYTE_CLK + 4, 1'b1);
		wait_idle(n);
		chk_tx(5, 8'h10);
		chk("start_no_wake", stq[0], {1'b0, 8'h2a});
	endtask
	task automatic t_bulk();
		int n;
		txq.delete();
		stq.delete();
		hold_tx = 1'b1;
		send(512, 8'h00);
		@(negedge i_clk_sys);
		chk("idle_low_full", o_idle_ind, 1'b0);
		hold_tx = 1'b0;
		wait_idle(n);
		chk_tx(512, 8'h00);
		chk("starts", stq.size(), 9);
	endtask
	// Pending data delays a change to sleep
	task automatic t_busy();
		int n;
		stq.delete();
		hold_tx = 1'b1;
		send(3, 8'h40);
		u_rmc_host_model.set_mode(2'h3, 0);
		repeat (SETTLE + 40) @(negedge i_clk_sys);
		chk("mode_held", o_mode, RMC_MODE_GENERAL);
		chk("idle_low_held", o_idle_ind, 1'b0);
		hold_tx = 1'b0;
		wait_idle(n);
		wait_mode(2'h3, n);
		chk("mode_sleep", o_mode, RMC_MODE_SLEEP);
		chk("switch_fast", n <= SETTLE + 8, 1'b1);
		chk("old_mode_pkt", stq[0][8], 1'b0);
	endtask
	task automatic t_modes();
		int n;
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'((i + 2) % 4);
			u_rmc_host_model.set_mode(m, 16);
			bound(u_rmc_host_model.wait_cyc);
			wait_mode(m, n);
			chk("mode", o_mode, m);
			chk("settle", n >= SETTLE, 1'b1);
			chk("rx_enable", o_rf_rx_enable, m != 2'h3);
		end
	endtask
	task automatic t_wake();
		int n;
		txq.delete();
		stq.delete();
		@(posedge i_clk_sys);
		wake_time <= 8'h15;
		send(3, 8'h60);
		wait_idle(n);
		chk_tx(3, 8'h60);
		chk("wake_start", stq[0], {1'b1, 8'h15});
	endtask
	// Radio packet out to serial after the lead
	task automatic t_rx();
		int k;
		int t0;
		u_rmc_host_model.got.delete();
		u_rmc_host_model.first_cyc = -1;
		u_rmc_host_model.slow = 1'b1;
		@(posedge i_clk_sys);
		for (int i = 0; i < 4; i++) begin
			i_rf_rx_valid <= 1'b1;
			i_rf_rx_data  <= 8'hc0 + i[7:0];
			i_rf_rx_last  <= (i == 3);
			k = 0;
			do begin
				@(negedge i_clk_sys);
				k++;
			end while (o_rf_rx_ready !== 1'b1 && k < 2000);
			bound(k);
			@(posedge i_clk_sys);
			if (i == 0)
				t0 = u_rmc_host_model.cyc;
		end
		i_rf_rx_valid <= 1'b0;
		i_rf_rx_data  <= 8'h3c;
		@(negedge i_clk_sys);
		chk("idle_low_rx", o_idle_ind, 1'b0);
		wait_idle(k);
		chk("lead", u_rmc_host_model.first_cyc - t0 >= LEAD, 1'b1);
		chk("out_count", u_rmc_host_model.got.size(), 4);
		for (int i = 0; i < 4; i++)
			chk("out_byte", u_rmc_host_model.got[i], 8'hc0 + i[7:0]);
	endtask
	initial begin
		t_reset();
		t_short();
		t_rx();
		t_bulk();
		t_busy();
		t_modes();
		t_wake();
		t_rx();
		end_sim();
	end
endmodule
`default_nettype wire
